// >>> rtl/status_indicator_driver.sv
// Functional notes
// - radio lamp lit while antenna transmits radio power, one clock cycle later.
// - outside continuous mode, link lamp flashes during tag transfers, else off.
// - in continuous mode, link lamp steady on, briefly off per tag access.
// - power lamp on whenever powered and out of reset.
// - five node lamps show node number bits, weights 16 down to 1.
// - default address lamp lit when address equals factory default.
// - user address lamp lit when address differs from factory default.
// - node lamps follow node number assignment one clock cycle later.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
module status_indicator_driver (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        rfTransmitting,
    input  wire logic        tagTransfer,
    input  wire logic        continuousMode,
    input  wire logic [4:0]  nodeNumber,
    input  wire logic [31:0] networkAddress,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             radio_activity_indicator,
    output logic             linkIndicator,
    output logic             power_indicator,
    output logic [4:0]       nodeIndicator,
    output logic             default_address_indicator,
    output logic             user_address_indicator
);

    typedef struct packed {
        status_indicator_pkg::link_state_t link;
        logic                              linkLamp;
        logic                              radioLamp;
        logic                              powerLamp;
        logic [4:0]                        nodeLamps;
        logic                              defLamp;
        logic                              userLamp;
        logic                              lampsEnable;
        logic                              forceTest;
        logic [31:0]                       togglePeriod;
        logic [31:0]                       blipPeriod;
        logic                              busDone;
        logic [31:0]                       readData;
    } drv_state_t;

    drv_state_t cur;
    drv_state_t next_cur;
    logic       timerRestart;
    logic       timerExpired;
    logic [31:0] timerPeriod;
    logic [31:0] wdata;
    logic [31:0] minCycles;

    // ------------------------------------------------------------------
    // shared flash / off pulse timer
    // ------------------------------------------------------------------
    blink_timer u_timer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .restart (timerRestart),
        .period  (timerPeriod),
        .expired (timerExpired)
    );

    assign timerPeriod  = (cur.link == status_indicator_pkg::LINK_BLIP) ?
                          cur.blipPeriod : cur.togglePeriod;
    assign timerRestart = (cur.link == status_indicator_pkg::LINK_IDLE);
    // both periods held at or above a tenth of a second
    assign minCycles    = status_indicator_pkg::CLK_HZ / 10;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        wdata    = cur.togglePeriod;
        // lamps follow their sources with one register stage
        next_cur.radioLamp = rfTransmitting;
        next_cur.powerLamp = 1'b1;
        next_cur.nodeLamps = nodeNumber;
        next_cur.defLamp   = (networkAddress == status_indicator_pkg::DEFAULT_ADDR);
        next_cur.userLamp  = (networkAddress != status_indicator_pkg::DEFAULT_ADDR);

        case (cur.link)
            status_indicator_pkg::LINK_IDLE: begin
                next_cur.linkLamp = continuousMode;
                if (tagTransfer) begin
                    if (continuousMode) begin
                        next_cur.link     = status_indicator_pkg::LINK_BLIP;
                        next_cur.linkLamp = 1'b0;
                    end else begin
                        next_cur.link     = status_indicator_pkg::LINK_FLASH;
                        next_cur.linkLamp = 1'b1;
                    end
                end
            end
            status_indicator_pkg::LINK_FLASH: begin
                if (continuousMode || !tagTransfer) begin
                    next_cur.link     = status_indicator_pkg::LINK_IDLE;
                    next_cur.linkLamp = continuousMode;
                end else if (timerExpired) begin
                    next_cur.linkLamp = !cur.linkLamp;
                end
            end
            status_indicator_pkg::LINK_BLIP: begin
                next_cur.linkLamp = 1'b0;
                if (timerExpired) begin
                    next_cur.link     = status_indicator_pkg::LINK_IDLE;
                    next_cur.linkLamp = continuousMode;
                end
            end
            default: begin
                next_cur.link     = status_indicator_pkg::LINK_IDLE;
                next_cur.linkLamp = 1'b0;
            end
        endcase

        // bus: every access answered one cycle after it is seen
        next_cur.busDone = (avs_read || avs_write) && !cur.busDone;
        if (avs_read && !cur.busDone) begin
            case (avs_address)
                status_indicator_pkg::OFF_CONTROL:
                    next_cur.readData = {30'h0, cur.forceTest, cur.lampsEnable};
                status_indicator_pkg::OFF_STATUS:
                    next_cur.readData = {19'h0, cur.nodeLamps, cur.userLamp, cur.defLamp,
                                         cur.powerLamp, cur.linkLamp, cur.radioLamp,
                                         continuousMode, tagTransfer, rfTransmitting};
                status_indicator_pkg::OFF_TOGGLE: next_cur.readData = cur.togglePeriod;
                status_indicator_pkg::OFF_BLIP:   next_cur.readData = cur.blipPeriod;
                default: next_cur.readData = status_indicator_pkg::UNMAPPED_DATA;
            endcase
        end
        // a write commits at the edge where waitrequest is seen low
        if (avs_write && cur.busDone) begin
            for (int b = 0; b < 4; b++) begin
                wdata[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8] : 8'h00;
            end
            case (avs_address)
                status_indicator_pkg::OFF_CONTROL: begin
                    if (avs_byteenable[0]) begin
                        next_cur.lampsEnable = avs_writedata[0];
                        next_cur.forceTest   = avs_writedata[1];
                    end
                end
                status_indicator_pkg::OFF_TOGGLE: begin
                    next_cur.togglePeriod = (wdata < minCycles) ? minCycles : wdata;
                end
                status_indicator_pkg::OFF_BLIP: begin
                    next_cur.blipPeriod = (wdata < minCycles) ? minCycles : wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur              <= '0;
            cur.link         <= status_indicator_pkg::LINK_IDLE;
            cur.lampsEnable  <= 1'b1;
            cur.togglePeriod <= status_indicator_pkg::TOGGLE_CYCLES;
            cur.blipPeriod   <= status_indicator_pkg::BLIP_CYCLES;
            cur.nodeLamps    <= status_indicator_pkg::NODE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !cur.busDone;
    assign avs_readdata    = cur.readData;

    // power lamp is not gated: it shows the unit is alive
    assign power_indicator           = cur.powerLamp;
    assign radio_activity_indicator  = cur.forceTest | (cur.lampsEnable & cur.radioLamp);
    assign linkIndicator             = cur.forceTest | (cur.lampsEnable & cur.linkLamp);
    assign nodeIndicator             = {5{cur.forceTest}} | ({5{cur.lampsEnable}} & cur.nodeLamps);
    assign default_address_indicator = cur.forceTest | (cur.lampsEnable & cur.defLamp);
    assign user_address_indicator    = cur.forceTest | (cur.lampsEnable & cur.userLamp);

endmodule

// >>> rtl/status_indicator_pkg.sv
package status_indicator_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned TOGGLE_MS       = 125;
    localparam int unsigned BLIP_MS         = 125;
    localparam int unsigned TOGGLE_CYCLES   = (CLK_HZ / 1000) * TOGGLE_MS;
    localparam int unsigned BLIP_CYCLES     = (CLK_HZ / 1000) * BLIP_MS;
    localparam int unsigned CNT_W           = 32;

    // ------------------------------------------------------------------
    // indicator layout
    // ------------------------------------------------------------------
    localparam int unsigned NODE_W          = 5;
    localparam int unsigned ADDR_W          = 32;
    localparam logic [31:0] DEFAULT_ADDR    = {8'd192, 8'd168, 8'd253, 8'd110};
    localparam logic [4:0]  NODE_RESET      = 5'h00;

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    localparam logic [3:0]  OFF_CONTROL     = 4'h0;
    localparam logic [3:0]  OFF_STATUS      = 4'h4;
    localparam logic [3:0]  OFF_TOGGLE      = 4'h8;
    localparam logic [3:0]  OFF_BLIP        = 4'hC;
    localparam logic [31:0] UNMAPPED_DATA   = 32'hDEADBEEF;

    typedef enum logic [2:0] {
        LINK_IDLE  = 3'b001,
        LINK_FLASH = 3'b010,
        LINK_BLIP  = 3'b100
    } link_state_t;

endpackage

// >>> rtl/blink_timer.sv
module blink_timer (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rstn,
    input  wire logic                                  restart,
    input  wire logic [status_indicator_pkg::CNT_W-1:0] period,
    output logic                                       expired
);

    typedef struct packed {
        logic [status_indicator_pkg::CNT_W-1:0] count;
        logic                                   expired;
    } timer_state_t;

    timer_state_t cur;
    timer_state_t next_cur;

    // ------------------------------------------------------------------
    // up counter, one-cycle pulse on reaching the period
    // ------------------------------------------------------------------
    always_comb begin
        next_cur         = cur;
        next_cur.expired = 1'b0;
        if (restart) begin
            next_cur.count = '0;
        end else if (cur.count + 32'd1 >= period) begin
            next_cur.count   = '0;
            next_cur.expired = 1'b1;
        end else begin
            next_cur.count = cur.count + 32'd1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = cur.expired;

endmodule

// >>> verif/status_indicator_driver_sva.sv
module status_indicator_sva (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        rfTransmitting,
    input wire logic        tagTransfer,
    input wire logic        continuousMode,
    input wire logic [4:0]  nodeNumber,
    input wire logic [31:0] networkAddress,
    input wire logic        radio_activity_indicator,
    input wire logic        linkIndicator,
    input wire logic        power_indicator,
    input wire logic [4:0]  nodeIndicator,
    input wire logic        default_address_indicator,
    input wire logic        user_address_indicator
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_radio_on: assert property (rfTransmitting |=> radio_activity_indicator)
        else $error("radio lamp dark while transmitting");
    a_radio_off: assert property (!rfTransmitting |=> !radio_activity_indicator)
        else $error("radio lamp lit while silent");
    a_link_idle: assert property ((!continuousMode && !tagTransfer) [*2] |=> !linkIndicator)
        else $error("link lamp lit with no transfer");
    a_link_start: assert property (!continuousMode && $rose(tagTransfer) |=> linkIndicator)
        else $error("link lamp not lit at transfer start");
    a_blip_off: assert property (continuousMode && $rose(tagTransfer) |=> !linkIndicator [*4])
        else $error("continuous mode off pulse too short");
    a_power_on: assert property ($past(rstn) |-> power_indicator)
        else $error("power lamp dark out of reset");
    a_node_follow: assert property (1'b1 |=> nodeIndicator == $past(nodeNumber))
        else $error("node lamps differ from node number");
    a_addr_default: assert property (networkAddress == status_indicator_pkg::DEFAULT_ADDR
        |=> default_address_indicator && !user_address_indicator)
        else $error("default address lamps wrong");
    a_addr_user: assert property (networkAddress != status_indicator_pkg::DEFAULT_ADDR
        |=> user_address_indicator && !default_address_indicator)
        else $error("user address lamps wrong");
    cover property (rfTransmitting ##1 radio_activity_indicator);
    cover property (continuousMode && $rose(tagTransfer));
    cover property (!continuousMode && tagTransfer ##1 linkIndicator);
endmodule

bind status_indicator_driver status_indicator_sva chk (
    .clk_sys                   (clk_sys),
    .rstn                      (rstn),
    .rfTransmitting            (rfTransmitting),
    .tagTransfer               (tagTransfer),
    .continuousMode            (continuousMode),
    .nodeNumber                (nodeNumber),
    .networkAddress            (networkAddress),
    .radio_activity_indicator  (radio_activity_indicator),
    .linkIndicator             (linkIndicator),
    .power_indicator           (power_indicator),
    .nodeIndicator             (nodeIndicator),
    .default_address_indicator (default_address_indicator),
    .user_address_indicator    (user_address_indicator)
);

// >>> verif/lamp_viewer.sv
module lamp_viewer (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic linkIndicator,
    output int        linkEdges
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastLink;
    // the operator counts how often the link lamp lights up
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lastLink <= 1'b0;
            linkEdges <= 0;
        end else begin
            lastLink <= linkIndicator;
            linkEdges <= linkEdges + int'(linkIndicator & ~lastLink);
        end
    end
endmodule

// >>> verif/status_indicator_driver_bench.sv
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin numErrors++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); end end
module status_indicator_driver_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys, rstn, rfTransmitting, tagTransfer, continuousMode, avs_read;
    logic        avs_write, avs_waitrequest, radio_activity_indicator, linkIndicator;
    logic        power_indicator, default_address_indicator, user_address_indicator;
    logic [4:0]  nodeNumber, nodeIndicator;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] networkAddress, avs_writedata, avs_readdata, rdData;
    int          numErrors, totalChecks, linkEdges;
    status_indicator_driver dut (
        .clk_sys                   (clk_sys),
        .rstn                      (rstn),
        .rfTransmitting            (rfTransmitting),
        .tagTransfer               (tagTransfer),
        .continuousMode            (continuousMode),
        .nodeNumber                (nodeNumber),
        .networkAddress            (networkAddress),
        .avs_address               (avs_address),
        .avs_read                  (avs_read),
        .avs_write                 (avs_write),
        .avs_writedata             (avs_writedata),
        .avs_byteenable            (avs_byteenable),
        .avs_readdata              (avs_readdata),
        .avs_waitrequest           (avs_waitrequest),
        .radio_activity_indicator  (radio_activity_indicator),
        .linkIndicator             (linkIndicator),
        .power_indicator           (power_indicator),
        .nodeIndicator             (nodeIndicator),
        .default_address_indicator (default_address_indicator),
        .user_address_indicator    (user_address_indicator)
    );
    lamp_viewer viewer (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .linkIndicator (linkIndicator),
        .linkEdges     (linkEdges)
    );
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic testDone();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // one bus request, held until waitrequest is seen low at a rising edge
    task automatic busAccess(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= data;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            numErrors++;
            testDone();
        end
        rdData = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        numErrors++;
        testDone();
    end
    initial begin
        {rstn, rfTransmitting, tagTransfer, continuousMode, avs_read, avs_write} = '0;
        {nodeNumber, avs_address, avs_writedata, numErrors, totalChecks} = '0;
        avs_byteenable = 4'hF;
        networkAddress = status_indicator_pkg::DEFAULT_ADDR;
        repeat (4) @(posedge clk_sys);
        `CHK(power_indicator, 1'b0)
        rstn <= 1'b1;
        settle(1);
        `CHK(power_indicator, 1'b1)
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk_sys);
            rfTransmitting <= i[0];
            settle(2);
            `CHK(radio_activity_indicator, i[0])
        end
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            nodeNumber <= i[4:0];
            settle(1);
            `CHK(nodeIndicator, i[4:0])
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            networkAddress <= status_indicator_pkg::DEFAULT_ADDR ^ (i[0] ? 32'h0 : 32'h1 << i);
            settle(2);
            `CHK(default_address_indicator, i[0])
            `CHK(user_address_indicator, ~i[0])
        end
        $display("test static lamps done");
        @(posedge clk_sys);
        tagTransfer <= 1'b1;
        settle(10);
        `CHK(linkIndicator, 1'b1)
        `CHK(linkEdges, 1)
        @(posedge clk_sys);
        tagTransfer <= 1'b0;
        settle(2);
        `CHK(linkIndicator, 1'b0)
        @(posedge clk_sys);
        continuousMode <= 1'b1;
        settle(2);
        `CHK(linkIndicator, 1'b1)
        @(posedge clk_sys);
        tagTransfer <= 1'b1;
        @(posedge clk_sys);
        tagTransfer <= 1'b0;
        settle(20);
        `CHK(linkIndicator, 1'b0)
        $display("test link lamp done");
        busAccess(1'b0, status_indicator_pkg::OFF_STATUS, 32'h00000000);
        `CHK(rdData[5], 1'b1)
        busAccess(1'b0, status_indicator_pkg::OFF_BLIP, 32'h00000000);
        `CHK(rdData, 32'h004C4B40)
        busAccess(1'b1, status_indicator_pkg::OFF_TOGGLE, 32'h00000001);
        busAccess(1'b0, status_indicator_pkg::OFF_TOGGLE, 32'h00000000);
        `CHK(rdData, 32'h003D0900)
        busAccess(1'b1, status_indicator_pkg::OFF_CONTROL, 32'h00000001);
        busAccess(1'b0, status_indicator_pkg::OFF_CONTROL, 32'h00000000);
        `CHK(rdData, 32'h00000001)
        busAccess(1'b0, 4'h2, 32'h00000000);
        `CHK(rdData, status_indicator_pkg::UNMAPPED_DATA)
        $display("test registers done");
        @(posedge clk_sys);
        continuousMode <= 1'b0;
        rstn <= 1'b0;
        settle(1);
        `CHK(power_indicator, 1'b0)
        @(posedge clk_sys);
        rstn <= 1'b1;
        settle(1);
        `CHK(power_indicator, 1'b1)
        `CHK(linkIndicator, 1'b0)
        $display("test second reset done");
        testDone();
    end
endmodule
